/* File: include/gps_port_pkg.sv */
package gps_port_pkg;

    // --------------------------------------------------------------
    // clock rates and times
    // --------------------------------------------------------------
    localparam int CORE_CLK_MHZ = 200;
    localparam int MASTER_CLK_MHZ = 40;
    localparam int PLL_LOCK_TIME_MS = 6;
    localparam int LOCK_CYCLES = PLL_LOCK_TIME_MS * 1000 * CORE_CLK_MHZ;
    localparam int LOCK_CNT_W = 21;

    // --------------------------------------------------------------
    // master clock divider
    // --------------------------------------------------------------
    localparam int DIV_W = 3;
    localparam logic [DIV_W-1:0] MCLK_DIV = DIV_W'(CORE_CLK_MHZ / MASTER_CLK_MHZ);
    localparam logic [DIV_W-1:0] FREE_RUN_DIV = 3'h4;
    localparam logic [DIV_W-1:0] MCLK_HIGH = 3'h2;
    localparam logic [DIV_W-1:0] DIV_ONE = 3'h1;

    // --------------------------------------------------------------
    // sample word and buffer
    // --------------------------------------------------------------
    localparam int SAMPLE_W = 2;
    localparam int SIGN_BIT = 1;
    localparam int MAG_BIT = 0;
    localparam int FIFO_DEPTH = 32;

    // --------------------------------------------------------------
    // synchroniser bit positions
    // --------------------------------------------------------------
    localparam int SYNC_W = 6;
    localparam int SYNC_POR = 0;
    localparam int SYNC_SHUT = 1;
    localparam int SYNC_TEST = 2;
    localparam int SYNC_SIGN = 3;
    localparam int SYNC_MAG = 4;
    localparam int SYNC_REQ = 5;

endpackage : gps_port_pkg

/* File: core/bit_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    // first stage feeds the second stage only
    always_comb begin
        state_next = state_reg;
        state_next.s1 = d;
        state_next.s2 = state_reg.s1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign q = state_reg.s2;

endmodule : bit_sync

`default_nettype wire

/* File: core/sample_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    // depth must be a power of two: pointers carry one wrap bit
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } fifo_state_t;

    fifo_state_t state_reg;
    fifo_state_t state_next;
    logic full;
    logic empty;

    assign full = (state_reg.wr_ptr[AW] != state_reg.rd_ptr[AW])
                  && (state_reg.wr_ptr[AW-1:0] == state_reg.rd_ptr[AW-1:0]);
    assign empty = (state_reg.wr_ptr == state_reg.rd_ptr);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = state_reg.mem[state_reg.rd_ptr[AW-1:0]];

    always_comb begin
        state_next = state_reg;
        if (in_valid && !full) begin
            state_next.mem[state_reg.wr_ptr[AW-1:0]] = in_data;
            state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
        end
        if (out_ready && !empty) begin
            state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
        end
        if (flush) begin
            state_next.wr_ptr = '0;
            state_next.rd_ptr = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : sample_fifo

`default_nettype wire

/* File: core/gps_frontend_sample_port.sv */
`timescale 1ns/1ps
`default_nettype none

module gps_frontend_sample_port #(
    parameter int LOCK_CYCLES = gps_port_pkg::LOCK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sample_clk,
    input wire logic quant_sign,
    input wire logic quant_mag,
    input wire logic por_threshold_input,
    input wire logic shutdown_control,
    input wire logic pll_open_test,
    output logic sign_out,
    output logic mag_out,
    output logic por_reset_flag,
    output logic pll_lock_flag,
    output logic master_clock_pair_p,
    output logic master_clock_pair_n
);

    // --------------------------------------------------------------
    // state types
    // --------------------------------------------------------------
    typedef struct packed {
        logic [gps_port_pkg::DIV_W-1:0] div_cnt;
        logic mclk_p;
        logic mclk_n;
        logic [gps_port_pkg::LOCK_CNT_W-1:0] lock_cnt;
        logic lock_flag;
        logic por_flag;
        logic req_seen;
        logic pend_valid;
        logic [gps_port_pkg::SAMPLE_W-1:0] pend_word;
        logic [gps_port_pkg::SAMPLE_W-1:0] stage;
        logic [gps_port_pkg::SAMPLE_W-1:0] quant_prev;
    } core_state_t;

    typedef struct packed {
        logic req_tgl;
        logic sign;
        logic mag;
    } link_state_t;

    core_state_t core_reg;
    core_state_t core_next;
    link_state_t link_reg;
    link_state_t link_next;

    // --------------------------------------------------------------
    // input synchronisers
    // --------------------------------------------------------------
    logic [gps_port_pkg::SYNC_W-1:0] sync_d;
    logic [gps_port_pkg::SYNC_W-1:0] sync_q;

    always_comb begin
        sync_d = '0;
        sync_d[gps_port_pkg::SYNC_POR] = por_threshold_input;
        sync_d[gps_port_pkg::SYNC_SHUT] = shutdown_control;
        sync_d[gps_port_pkg::SYNC_TEST] = pll_open_test;
        sync_d[gps_port_pkg::SYNC_SIGN] = quant_sign;
        sync_d[gps_port_pkg::SYNC_MAG] = quant_mag;
        sync_d[gps_port_pkg::SYNC_REQ] = link_reg.req_tgl;
    end

    bit_sync #(
        .WIDTH(gps_port_pkg::SYNC_W)
    ) u_sync (
        .clk(core_clk),
        .rst(rst),
        .d(sync_d),
        .q(sync_q)
    );

    logic shut;
    logic test_open;
    logic req_edge;
    logic [gps_port_pkg::SAMPLE_W-1:0] quant_sync;
    logic quant_steady;

    assign shut = sync_q[gps_port_pkg::SYNC_SHUT];
    assign test_open = sync_q[gps_port_pkg::SYNC_TEST];
    assign req_edge = sync_q[gps_port_pkg::SYNC_REQ] ^ core_reg.req_seen;

    always_comb begin
        quant_sync = '0;
        quant_sync[gps_port_pkg::SIGN_BIT] = sync_q[gps_port_pkg::SYNC_SIGN];
        quant_sync[gps_port_pkg::MAG_BIT] = sync_q[gps_port_pkg::SYNC_MAG];
    end

    // the two quantiser bits cross separately; a word is taken only
    // once both agree over two cycles, so no torn word gets in
    assign quant_steady = (quant_sync == core_reg.quant_prev);

    // --------------------------------------------------------------
    // sample buffer
    // --------------------------------------------------------------
    // conversions run at the master clock rate, far above the
    // sample clock, so the buffer fills and then stalls conversion
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [gps_port_pkg::SAMPLE_W-1:0] fifo_out_data;

    sample_fifo #(
        .WIDTH(gps_port_pkg::SAMPLE_W),
        .DEPTH(gps_port_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(core_clk),
        .rst(rst),
        .flush(shut),
        .in_valid(core_reg.pend_valid),
        .in_ready(fifo_in_ready),
        .in_data(core_reg.pend_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // --------------------------------------------------------------
    // core clock domain
    // --------------------------------------------------------------
    logic [gps_port_pkg::DIV_W-1:0] div_last;
    logic conv_tick;
    logic pend_free;

    always_comb begin
        core_next = core_reg;
        fifo_pop = 1'b0;
        div_last = gps_port_pkg::MCLK_DIV - gps_port_pkg::DIV_ONE;
        conv_tick = 1'b0;
        pend_free = 1'b0;

        // comparator result passes even in shutdown
        core_next.por_flag = sync_q[gps_port_pkg::SYNC_POR];
        core_next.req_seen = sync_q[gps_port_pkg::SYNC_REQ];
        core_next.quant_prev = quant_sync;

        if (shut) begin
            // divider, lock and pending word are parked; the por path and request tracking still run
            // parked at the wrap point so the first pulse on wake is full
            core_next.div_cnt = div_last;
            core_next.mclk_p = 1'b0;
            core_next.mclk_n = 1'b1;
            core_next.lock_cnt = '0;
            core_next.lock_flag = 1'b0;
            core_next.pend_valid = 1'b0;
            // cleared only right after a request, when the far domain
            // is known not to be sampling it
            if (req_edge) begin
                core_next.stage = '0;
            end
        end else begin
            // an open loop lets the oscillator run fast
            if (test_open) begin
                div_last = gps_port_pkg::FREE_RUN_DIV - gps_port_pkg::DIV_ONE;
            end

            if (core_reg.div_cnt >= div_last) begin
                core_next.div_cnt = '0;
            end else begin
                core_next.div_cnt = core_reg.div_cnt + gps_port_pkg::DIV_ONE;
            end

            // both sides from one compare, so never equal
            core_next.mclk_p = (core_next.div_cnt < gps_port_pkg::MCLK_HIGH);
            core_next.mclk_n = !(core_next.div_cnt < gps_port_pkg::MCLK_HIGH);

            // one conversion per master clock period
            conv_tick = (core_reg.div_cnt == '0);
            pend_free = !core_reg.pend_valid || fifo_in_ready;

            if (core_reg.pend_valid && fifo_in_ready) begin
                core_next.pend_valid = 1'b0;
            end

            // a full buffer skips conversions rather than overwrite
            if (conv_tick && pend_free && quant_steady) begin
                core_next.pend_valid = 1'b1;
                core_next.pend_word = core_reg.quant_prev;
            end

            // each sample clock edge asks for the next word; the stage
            // then stays put for the rest of that sample period until the next edge reads it
            if (req_edge && fifo_out_valid) begin
                fifo_pop = 1'b1;
                core_next.stage = fifo_out_data;
            end

            // lock is declared once the loop has settled
            if (test_open) begin
                core_next.lock_cnt = '0;
                core_next.lock_flag = 1'b0;
            end else if (core_reg.lock_cnt
                         >= gps_port_pkg::LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
                core_next.lock_flag = 1'b1;
            end else begin
                core_next.lock_cnt = core_reg.lock_cnt + 1'b1;
                core_next.lock_flag = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            core_reg <= '0;
            core_reg.mclk_n <= 1'b1;
            core_reg.div_cnt <= gps_port_pkg::MCLK_DIV - gps_port_pkg::DIV_ONE;
        end else begin
            core_reg <= core_next;
        end
    end

    // --------------------------------------------------------------
    // sample clock domain
    // --------------------------------------------------------------
    // reset leaves this domain only after two of its own edges, so the
    // first live edge never races the release of rst
    logic link_live;

    bit_sync #(
        .WIDTH(1)
    ) u_link_rst (
        .clk(sample_clk),
        .rst(rst),
        .d(1'b1),
        .q(link_live)
    );

    // the sample clock may stop; nothing here relies on a later edge
    always_comb begin
        link_next = link_reg;
        if (link_live) begin
            link_next.req_tgl = !link_reg.req_tgl;
            link_next.sign = core_reg.stage[gps_port_pkg::SIGN_BIT];
            link_next.mag = core_reg.stage[gps_port_pkg::MAG_BIT];
        end
    end

    // outputs change only on a rising sample clock edge
    always_ff @(posedge sample_clk or posedge rst) begin
        if (rst) begin
            link_reg <= '0;
        end else begin
            link_reg <= link_next;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign sign_out = link_reg.sign;
    assign mag_out = link_reg.mag;
    assign por_reset_flag = core_reg.por_flag;
    assign pll_lock_flag = core_reg.lock_flag;
    assign master_clock_pair_p = core_reg.mclk_p;
    assign master_clock_pair_n = core_reg.mclk_n;

endmodule : gps_frontend_sample_port

`default_nettype wire

/* File: verif/gps_port_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module gps_port_checker #(
    parameter int LOCK_CYCLES = gps_port_pkg::LOCK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sample_clk,
    input wire logic por_threshold_input,
    input wire logic shutdown_control,
    input wire logic pll_open_test,
    input wire logic sign_out,
    input wire logic mag_out,
    input wire logic por_reset_flag,
    input wire logic pll_lock_flag,
    input wire logic master_clock_pair_p,
    input wire logic master_clock_pair_n
);
    // ------------------------------
    // cycles since shutdown or test pin last high
    // ------------------------------
    int run_reg;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) run_reg <= 0;
        else if (shutdown_control || pll_open_test) run_reg <= 0;
        else if (run_reg < 32'h7FFFFFF0) run_reg <= run_reg + 1;
    end
    // ------------------------------
    // properties
    // ------------------------------
    pair_compl_a: assert property (@(posedge core_clk) disable iff (rst)
        master_clock_pair_n == !master_clock_pair_p) else $error("pair not complementary");
    clk_period_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(master_clock_pair_p) && run_reg > 10 |-> $past(master_clock_pair_p, 5)
        && $past(master_clock_pair_p, 4) && !$past(master_clock_pair_p, 3))
        else $error("master clock period wrong");
    clk_duty_a: assert property (@(posedge core_clk) disable iff (rst)
        !shutdown_control [*3] ##1 $rose(master_clock_pair_p) |=> master_clock_pair_p
        ##1 !master_clock_pair_p) else $error("master clock high time wrong");
    shut_park_a: assert property (@(posedge core_clk) disable iff (rst)
        shutdown_control [*4] |-> !master_clock_pair_p && !pll_lock_flag)
        else $error("shutdown did not park");
    por_high_a: assert property (@(posedge core_clk) disable iff (rst)
        por_threshold_input [*4] |-> por_reset_flag) else $error("por flag not high");
    por_low_a: assert property (@(posedge core_clk) disable iff (rst)
        !por_threshold_input [*4] |-> !por_reset_flag) else $error("por flag not low");
    por_shut_a: assert property (@(posedge core_clk) disable iff (rst)
        (shutdown_control && por_threshold_input) [*4] |-> por_reset_flag)
        else $error("por flag lost in shutdown");
    test_unlock_a: assert property (@(posedge core_clk) disable iff (rst)
        pll_open_test [*4] |-> !pll_lock_flag) else $error("lock high with loop open");
    lock_early_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(pll_lock_flag) |-> run_reg >= LOCK_CYCLES) else $error("lock too early");
    out_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        $changed({sign_out, mag_out}) |-> $rose(sample_clk))
        else $error("sample output moved between edges");
    out_shut_a: assert property (@(posedge sample_clk) disable iff (rst)
        shutdown_control [*4] |-> !sign_out && !mag_out) else $error("samples in shutdown");
    cover property (@(posedge core_clk) $rose(pll_lock_flag));
    cover property (@(posedge core_clk) $fell(pll_lock_flag) && pll_open_test);
    cover property (@(posedge sample_clk) sign_out && mag_out);
endmodule : gps_port_checker
bind gps_frontend_sample_port gps_port_checker #(.LOCK_CYCLES(LOCK_CYCLES)) gps_port_checker_inst (
    .core_clk(core_clk), .rst(rst), .sample_clk(sample_clk),
    .por_threshold_input(por_threshold_input), .shutdown_control(shutdown_control),
    .pll_open_test(pll_open_test), .sign_out(sign_out), .mag_out(mag_out),
    .por_reset_flag(por_reset_flag), .pll_lock_flag(pll_lock_flag),
    .master_clock_pair_p(master_clock_pair_p), .master_clock_pair_n(master_clock_pair_n));
`default_nettype wire

/* File: verif/correlator_model.sv */
`timescale 1ns/1ps
`default_nettype none
module correlator_model (
    input wire logic run,
    input wire logic sign_out,
    input wire logic mag_out,
    output logic sample_clk,
    output logic [1:0] word_seen
);
    // ------------------------------
    // 48 ns sample clock, parked low when not running
    // ------------------------------
    initial begin
        sample_clk = 1'h0;
        word_seen = 2'h0;
        #1.3;
        forever begin
            #24;
            if (run || sample_clk) sample_clk = ~sample_clk;
        end
    end
    always @(posedge sample_clk) word_seen <= {sign_out, mag_out};
endmodule : correlator_model
`default_nettype wire

/* File: verif/tb_gps_frontend_sample_port.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_gps_frontend_sample_port;
    localparam int LOCK_N = 50;
    logic core_clk, rst, sample_clk, run, quant_sign, quant_mag;
    logic por_threshold_input, shutdown_control, pll_open_test;
    logic sign_out, mag_out, por_reset_flag, pll_lock_flag, mclk_p, mclk_n;
    logic [1:0] word_seen, w;
    int error_cnt, checks, n;

    gps_frontend_sample_port #(.LOCK_CYCLES(LOCK_N)) gps_frontend_sample_port_inst (
        .core_clk(core_clk), .rst(rst), .sample_clk(sample_clk), .quant_sign(quant_sign),
        .quant_mag(quant_mag), .por_threshold_input(por_threshold_input),
        .shutdown_control(shutdown_control), .pll_open_test(pll_open_test),
        .sign_out(sign_out), .mag_out(mag_out), .por_reset_flag(por_reset_flag),
        .pll_lock_flag(pll_lock_flag), .master_clock_pair_p(mclk_p),
        .master_clock_pair_n(mclk_n));
    correlator_model correlator_model_inst (.run(run), .sign_out(sign_out),
        .mag_out(mag_out), .sample_clk(sample_clk), .word_seen(word_seen));
    // ------------------------------
    // helpers
    // ------------------------------
    function automatic int mclk_period(input logic open);
        return open ? 4 : 5;
    endfunction : mclk_period
    function automatic logic [1:0] word_expect(input logic sd, input logic [1:0] q);
        return sd ? 2'h0 : q;
    endfunction : word_expect
    // sampling 1 ns after the edge keeps clear of the design's own update
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic check_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit
    task automatic check_num(input string what, input int exp, input int got);
        checks++;
        if (got != exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_num
    task automatic period(output int p);
        while (mclk_p !== 1'h0) cyc(1);
        while (mclk_p !== 1'h1) cyc(1);
        p = 0;
        do begin cyc(1); p++; end while (mclk_p !== 1'h0);
        do begin cyc(1); p++; end while (mclk_p !== 1'h1);
    endtask : period
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    // ------------------------------
    // stimulus
    // ------------------------------
    initial begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        error_cnt++;
        $display("[FAIL] watchdog expected done seen timeout");
        conclude();
    end
    initial begin
        error_cnt = 0;
        checks = 0;
        rst = 1'h1;
        run = 1'h1;
        {quant_sign, quant_mag, por_threshold_input, shutdown_control, pll_open_test} = 5'h00;
        void'($urandom(3193));
        repeat (16) @(posedge core_clk);
        rst <= 1'h0;
        cyc(LOCK_N / 2);
        check_bit("lock early", 1'h0, pll_lock_flag);
        cyc(LOCK_N);
        check_bit("lock", 1'h1, pll_lock_flag);
        period(n);
        check_num("period", mclk_period(1'h0), n);
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            check_bit("pair", ~mclk_p, mclk_n);
        end
        $display("test clock done");
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            por_threshold_input <= 1'($urandom);
            shutdown_control <= 1'(i);
            cyc(5);
            check_bit("por", por_threshold_input, por_reset_flag);
        end
        @(posedge core_clk);
        shutdown_control <= 1'h0;
        $display("test por done");
        for (int i = 0; i < 6; i++) begin
            w = (i < 4) ? 2'(i) : 2'($urandom);
            @(posedge core_clk);
            {quant_sign, quant_mag} <= w;
            repeat (48) @(posedge sample_clk);
            cyc(1);
            check_bit("sign", w[1], sign_out);
            check_bit("mag", w[0], mag_out);
            check_bit("seen sign", w[1], word_seen[1]);
        end
        run <= 1'h0;
        cyc(20);
        @(posedge core_clk);
        {quant_sign, quant_mag} <= ~w;
        cyc(60);
        check_bit("hold sign", w[1], sign_out);
        check_bit("hold mag", w[0], mag_out);
        run <= 1'h1;
        $display("test samples done");
        @(posedge core_clk);
        pll_open_test <= 1'h1;
        cyc(6);
        check_bit("lock open", 1'h0, pll_lock_flag);
        period(n);
        check_num("free period", mclk_period(1'h1), n);
        @(posedge core_clk);
        pll_open_test <= 1'h0;
        cyc(LOCK_N + 10);
        check_bit("relock", 1'h1, pll_lock_flag);
        $display("test loop done");
        @(posedge core_clk);
        shutdown_control <= 1'h1;
        repeat (5) @(posedge sample_clk);
        cyc(1);
        check_bit("park p", 1'h0, mclk_p);
        check_bit("park n", 1'h1, mclk_n);
        check_bit("lock off", 1'h0, pll_lock_flag);
        w = word_expect(1'h1, w);
        check_bit("sign off", w[1], sign_out);
        check_bit("mag off", w[0], mag_out);
        @(posedge core_clk);
        shutdown_control <= 1'h0;
        cyc(LOCK_N + 10);
        check_bit("wake lock", 1'h1, pll_lock_flag);
        period(n);
        check_num("wake period", mclk_period(1'h0), n);
        $display("test shutdown done");
        conclude();
    end
endmodule : tb_gps_frontend_sample_port
`default_nettype wire
